// >>> src/gpic_map.svh
// register-free constants for the gated prescaled input capture block
`ifndef GPIC_MAP_SVH
`define GPIC_MAP_SVH
`define GPIC_NUM_CH 8
`define GPIC_TW 16
`define GPIC_OVF_BIT14 14
`define GPIC_OVF_BIT15 15
`define GPIC_FILT_TAPS 3
`define GPIC_FDIV_W 3
`define GPIC_PSC_W 8
`define GPIC_NPIN 2
`define GPIC_GATE_CH_A 6
`define GPIC_GATE_CH_B 7
`define GPIC_REL_IDX_A 4
`define GPIC_REL_IDX_B 5
`endif

// >>> src/gpic_pkg.sv
// types for the gated prescaled input capture block
package gpic_pkg;
  typedef enum logic [1:0] {
    GPIC_EDGE_RISE,
    GPIC_EDGE_FALL,
    GPIC_EDGE_BOTH
  } gpic_edge_e;
  typedef enum logic {
    GPIC_GATE_OPEN,
    GPIC_GATE_SHUT
  } gpic_gate_e;
endpackage : gpic_pkg

// >>> src/gpic_trig_if.sv
// trigger path from one channel filter to the capture logic
`timescale 1ns/100ps
interface gpic_trig_if;
  logic level;
  modport filt (output level);
  modport cap (input level);
endinterface : gpic_trig_if

// >>> src/gpic_filter.sv
// digital noise filter for one capture input
`timescale 1ns/100ps
`include "gpic_map.svh"
module gpic_filter (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic raw_in,
  input wire logic enable_in,
  input wire logic [`GPIC_FDIV_W-1:0] div_in,
  gpic_trig_if.filt trig
);
  logic [`GPIC_FDIV_W-1:0] div_cnt;
  logic tick;
  logic [`GPIC_FILT_TAPS-1:0] taps;
  logic stable;

  assign tick = (div_cnt == div_in);

  // filter clock is a divided strobe, chosen per channel
  always_ff @(posedge clk_in) begin
    if (reset_in || tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      taps <= '0;
    end else if (tick) begin
      taps <= {taps[`GPIC_FILT_TAPS-2:0], raw_in};
    end
  end

  // level changes only after all taps agree
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      stable <= 1'b0;
    end else if (&taps) begin
      stable <= 1'b1;
    end else if (~|taps) begin
      stable <= 1'b0;
    end
  end

  assign trig.level = enable_in ? raw_in : stable;
endmodule : gpic_filter

// >>> src/gpic_capture.sv
// eight-channel input capture with gate and prescaler on channels 6 and 7
//
// How it works
// - the overflow pulse comes from bit 14 or bit 15 of the base timer.
// - an enabled filter cleans each input on its own divided clock.
// - each capture raises an event pulse when that channel is enabled.
// - with the gate on, the first measurement shuts further triggers.
// - gate, release and prescaler exist on channels 6 and 7 only.
// - release reopens the gate when compare 4 or 5 equals the timer.
// - without the prescaler every accepted trigger is measured.
// - with the prescaler one trigger in value plus one is measured.
// - triggers come from rising, falling or both edges as selected.
// - each channel picks its trigger from one of two pins.
`timescale 1ns/100ps
`include "gpic_map.svh"
module gpic_capture (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic run_in,
  input wire logic ovf_sel15_in,
  input wire logic [`GPIC_NPIN*`GPIC_NUM_CH-1:0] pins_in,
  input wire logic [`GPIC_NUM_CH-1:0] pin_sel_in,
  input wire logic [`GPIC_NUM_CH-1:0] filt_en_in,
  input wire logic [`GPIC_FDIV_W*`GPIC_NUM_CH-1:0] filt_div_in,
  input wire logic [2*`GPIC_NUM_CH-1:0] edge_sel_in,
  input wire logic [`GPIC_NUM_CH-1:0] irq_en_in,
  input wire logic [`GPIC_NUM_CH-1:0] flag_clr_in,
  input wire logic [1:0] gate_en_in,
  input wire logic [1:0] gate_rel_en_in,
  input wire logic [1:0] psc_en_in,
  input wire logic [2*`GPIC_PSC_W-1:0] psc_val_in,
  input wire logic [`GPIC_TW-1:0] rel_cmp4_in,
  input wire logic [`GPIC_TW-1:0] rel_cmp5_in,
  output logic [`GPIC_TW-1:0] base_out,
  output logic ovf_out,
  output logic [`GPIC_TW*`GPIC_NUM_CH-1:0] cap_out,
  output logic [`GPIC_NUM_CH-1:0] flag_out,
  output logic [`GPIC_NUM_CH-1:0] irq_out,
  output logic [1:0] gate_shut_out
);
  logic [`GPIC_TW-1:0] base;
  logic [`GPIC_NUM_CH-1:0] meas;

  // ------------------------------------------------------------
  // base timer
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      base <= '0;
    end else if (run_in) begin
      base <= base + 1'b1;
    end
  end
  assign base_out = base;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ovf_out <= 1'b0;
    end else if (ovf_sel15_in) begin
      ovf_out <= run_in && (&base[`GPIC_OVF_BIT15:0]);
    end else begin
      ovf_out <= run_in && (&base[`GPIC_OVF_BIT14:0]);
    end
  end

  // ------------------------------------------------------------
  // per-channel trigger path
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `GPIC_NUM_CH; i++) begin : g_ch
      gpic_trig_if tif ();
      logic [1:0] sync;
      logic prev;
      logic trig;
      logic accept;
      logic [1:0] esel;
      assign esel = edge_sel_in[2*i +: 2];

      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          sync <= '0;
        end else begin
          sync <= {sync[0], pins_in[`GPIC_NPIN*i + 32'(pin_sel_in[i])]};
        end
      end

      // filter on sync output; filt_en high selects the filtered path
      gpic_filter u_filt (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .raw_in(sync[1]),
        .enable_in(~filt_en_in[i]),
        .div_in(filt_div_in[`GPIC_FDIV_W*i +: `GPIC_FDIV_W]),
        .trig(tif.filt)
      );

      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          prev <= 1'b0;
        end else begin
          prev <= tif.level;
        end
      end

      always_comb begin
        case (esel)
          2'h0: trig = tif.level & ~prev;
          2'h1: trig = ~tif.level & prev;
          default: trig = tif.level ^ prev;
        endcase
      end

      // gate and prescaler only on the upper two channels
      if (i == `GPIC_GATE_CH_A || i == `GPIC_GATE_CH_B) begin : g_gate
        localparam int K = i - `GPIC_GATE_CH_A;
        gpic_pkg::gpic_gate_e gate;
        logic [`GPIC_PSC_W-1:0] pcnt;
        logic rel_hit;
        assign rel_hit = (K == 0) ? (rel_cmp4_in == base)
                                  : (rel_cmp5_in == base);
        assign accept = trig && run_in &&
                        !(gate_en_in[K] && gate == gpic_pkg::GPIC_GATE_SHUT);

        // measure every accepted trigger or every n+1
        always_ff @(posedge clk_in) begin
          if (reset_in || !psc_en_in[K]) begin
            pcnt <= '0;
          end else if (accept) begin
            if (pcnt == psc_val_in[`GPIC_PSC_W*K +: `GPIC_PSC_W]) begin
              pcnt <= '0;
            end else begin
              pcnt <= pcnt + 1'b1;
            end
          end
        end
        assign meas[i] = accept && (!psc_en_in[K] ||
          pcnt == psc_val_in[`GPIC_PSC_W*K +: `GPIC_PSC_W]);

        // shut after measurement, reopen on compare match
        always_ff @(posedge clk_in) begin
          if (reset_in || !gate_en_in[K]) begin
            gate <= gpic_pkg::GPIC_GATE_OPEN;
          end else if (meas[i]) begin
            gate <= gpic_pkg::GPIC_GATE_SHUT;
          end else if (gate_rel_en_in[K] && rel_hit) begin
            gate <= gpic_pkg::GPIC_GATE_OPEN;
          end
        end
        always_ff @(posedge clk_in) begin
          if (reset_in) begin
            gate_shut_out[K] <= 1'b0;
          end else begin
            // mirrors the next gate state so the port never lags a release
            gate_shut_out[K] <= gate_en_in[K] && (meas[i] ||
              (gate == gpic_pkg::GPIC_GATE_SHUT &&
               !(gate_rel_en_in[K] && rel_hit)));
          end
        end
      end else begin : g_plain
        assign accept = trig && run_in;
        assign meas[i] = accept;
      end

      // capture timer value, flag set wins over clear
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          cap_out[`GPIC_TW*i +: `GPIC_TW] <= '0;
        end else if (meas[i]) begin
          cap_out[`GPIC_TW*i +: `GPIC_TW] <= base;
        end
      end
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          flag_out[i] <= 1'b0;
        end else if (meas[i]) begin
          flag_out[i] <= 1'b1;
        end else if (flag_clr_in[i]) begin
          flag_out[i] <= 1'b0;
        end
      end

      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          irq_out[i] <= 1'b0;
        end else begin
          irq_out[i] <= meas[i] && irq_en_in[i];
        end
      end
    end
  endgenerate
endmodule : gpic_capture

// >>> testbench/gpic_chk.sv
// port checker for the capture block
`timescale 1ns/100ps
module gpic_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ovf_sel15_in,
  input wire logic [7:0] irq_en_in,
  input wire logic [1:0] gate_en_in,
  input wire logic [1:0] gate_rel_en_in,
  input wire logic [15:0] rel_cmp4_in,
  input wire logic [15:0] rel_cmp5_in,
  input wire logic [15:0] base_out,
  input wire logic ovf_out,
  input wire logic [127:0] cap_out,
  input wire logic [7:0] irq_out,
  input wire logic [7:0] flag_out,
  input wire logic [1:0] gate_shut_out
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  capture_value_a: assert property (irq_out[0] |->
    cap_out[15:0] == $past(base_out)) else $error("bad capture");
  flag_set_a: assert property (irq_out[0] |-> flag_out[0])
    else $error("flag not set");
  irq_enable_a: assert property ((irq_out & ~$past(irq_en_in)) == 0)
    else $error("event while off");
  ovf_point_a: assert property (ovf_out |->
    base_out[14:0] == 0 &&
    !($past(ovf_sel15_in) && base_out[15])) else $error("bad ovf");
  gate_block_a: assert property ($past(gate_shut_out[1] & gate_en_in[1])
    |-> $stable(cap_out[127:112])) else $error("shut gate took");
  gate_shut_a: assert property (irq_out[7] && $past(gate_en_in[1])
    |-> gate_shut_out[1]) else $error("gate left open");
  release_six_a: assert property (gate_shut_out[0] && gate_rel_en_in[0]
    && base_out == rel_cmp4_in |=> !gate_shut_out[0]) else $error("no rel");
  release_svn_a: assert property (gate_shut_out[1] && gate_rel_en_in[1]
    && base_out == rel_cmp5_in |=> !gate_shut_out[1]) else $error("no rel");
  gate_off_a: assert property ((gate_shut_out & ~$past(gate_en_in)) == 0)
    else $error("gate while off");
  cover property (irq_out[6]);
  cover property (gate_shut_out[1]);
  cover property (ovf_out);
endmodule : gpic_chk
bind gpic_capture gpic_chk i_chk (.clk_in, .reset_in, .ovf_sel15_in,
  .irq_en_in, .gate_en_in, .gate_rel_en_in, .rel_cmp4_in, .rel_cmp5_in,
  .base_out, .ovf_out, .cap_out, .irq_out, .flag_out, .gate_shut_out);

// >>> testbench/gpic_src.sv
// external trigger source on the capture pins
`timescale 1ns/100ps
module gpic_src (
  input wire logic clk_in,
  output logic [15:0] pins_out
);
  initial pins_out = 16'h0000;
  // toggles masked pins n times, g clocks apart, just after an edge
  task automatic edges(input logic [15:0] m, input int n, input int g);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_in);
      #1 pins_out = pins_out ^ m;
      repeat (g - 1) @(posedge clk_in);
    end
  endtask : edges
endmodule : gpic_src

// >>> testbench/testbench.sv
// self-checking bench for the capture block
`timescale 1ns/100ps
module testbench;
  logic clk_in, reset_in, run_in, ovf_sel15_in, ovf_out;
  logic [7:0] pin_sel_in, filt_en_in, irq_en_in, flag_clr_in;
  logic [7:0] flag_out, irq_out;
  logic [1:0] gate_en_in, gate_rel_en_in, psc_en_in, gate_shut_out;
  logic [15:0] pins_in, edge_sel_in, psc_val_in, rel_cmp4_in;
  logic [15:0] rel_cmp5_in, base_out, b;
  logic [23:0] filt_div_in;
  logic [127:0] cap_out;
  int num_errors, num_checks, tn, i, nirq[8];
  gpic_capture i_dut (.clk_in, .reset_in, .run_in, .ovf_sel15_in, .pins_in,
    .pin_sel_in, .filt_en_in, .filt_div_in, .edge_sel_in, .irq_en_in,
    .flag_clr_in, .gate_en_in, .gate_rel_en_in, .psc_en_in, .psc_val_in,
    .rel_cmp4_in, .rel_cmp5_in, .base_out, .ovf_out, .cap_out, .flag_out,
    .irq_out, .gate_shut_out);
  gpic_src i_src (.clk_in, .pins_out(pins_in));
  initial begin
    clk_in = 0;
    forever #10 clk_in = ~clk_in;
  end
  // irq pulses are counted mid-cycle, clear of the launching edge
  always @(negedge clk_in)
    for (int c = 0; c < 8; c++)
      nirq[c] += irq_out[c];
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e);
    num_errors += (g !== e);
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : w
  task automatic tend();
    tn++;
    $display("test %0d done", tn);
  endtask : tend
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    {reset_in, run_in, ovf_sel15_in} = 3'h4;
    {pin_sel_in, filt_en_in, irq_en_in, flag_clr_in} = 32'h0204FF00;
    {gate_en_in, gate_rel_en_in, psc_en_in} = 6'h00;
    {edge_sel_in, psc_val_in, rel_cmp4_in, rel_cmp5_in} = 64'h2;
    filt_div_in = 24'h000040;
    w(6);
    {reset_in, run_in} = 2'h1;
    for (i = 0; i < 4; i++) begin
      edge_sel_in[1:0] = i[1:0];
      nirq = '{default: 0};
      i_src.edges(16'h0001, 2, 8);
      w(8);
      chk(nirq[0], i > 1 ? 2 : 1);
    end
    tend();
    edge_sel_in[1:0] = 2'h0;
    i_src.edges(16'h0001, 1, 1);
    b = base_out;
    w(3);
    chk(cap_out[15:0], b + 16'h0002);
    chk(flag_out[0], 1);
    i_src.edges(16'h0001, 1, 8);
    {irq_en_in, flag_clr_in} = 16'hFE01;
    w(1);
    flag_clr_in = 8'h00;
    w(1);
    chk(flag_out[0], 0);
    nirq = '{default: 0};
    i_src.edges(16'h0001, 2, 8);
    w(4);
    chk(nirq[0], 0);
    chk(flag_out[0], 1);
    irq_en_in = 8'hFF;
    tend();
    edge_sel_in[3:2] = 2'h3;
    i_src.edges(16'h0004, 2, 8);
    i_src.edges(16'h0008, 2, 8);
    i_src.edges(16'h0010, 2, 2);
    w(20);
    chk(nirq[2], 0);
    i_src.edges(16'h0010, 2, 30);
    w(20);
    chk(nirq[1], 2);
    chk(nirq[2], 1);
    tend();
    {psc_en_in, psc_val_in} = 18'h10002;
    nirq = '{default: 0};
    i_src.edges(16'h5000, 12, 4);
    w(8);
    chk(nirq[6], 2);
    chk(nirq[7], 6);
    {psc_en_in, gate_en_in, gate_rel_en_in} = 6'h0F;
    tend();
    rel_cmp4_in = base_out + 16'h0100;
    rel_cmp5_in = rel_cmp4_in;
    nirq = '{default: 0};
    i_src.edges(16'h5001, 6, 4);
    w(8);
    chk(nirq[6], 1);
    chk(nirq[7], 1);
    chk(nirq[0], 3);
    chk(gate_shut_out, 3);
    for (i = 0; i < 400 && gate_shut_out !== 2'h0; i++)
      w(1);
    chk(gate_shut_out, 0);
    if (i == 400)
      stop_test();
    i_src.edges(16'h5000, 2, 4);
    w(8);
    chk(nirq[6], 2);
    tend();
    for (i = 0; i < 40000 && ovf_out !== 1'b1; i++)
      w(1);
    chk(base_out[14:0], 0);
    if (i == 40000)
      stop_test();
    tend();
    stop_test();
  end
endmodule : testbench
